// ### src/pmc_pkg.sv
// Purpose: constants and types shared by the power mode controller
// Assumes: 8-bit register data, 125 MHz core clock
// Notes:   register offsets are word indices on the plain register port
package pmc_pkg;
   localparam int          ADDR_W          = 3;
   localparam int          DATA_W          = 8;
   localparam int          VEC_W           = 16;

   localparam logic [2:0]  OFS_POWER_CTRL  = 3'h0;
   localparam logic [2:0]  OFS_POWER_CFG   = 3'h1;
   localparam logic [2:0]  OFS_FLASH_TIME  = 3'h2;
   localparam logic [2:0]  OFS_CLK_CTRL    = 3'h3;
   localparam logic [2:0]  OFS_STATUS      = 3'h4;

   // power_control_reg
   localparam int          BIT_IDLE_SEL    = 0;
   localparam int          BIT_STOP_SEL    = 1;
   // power_cfg_reg
   localparam int          BIT_SLEEP_SEL   = 7;
   localparam int          BIT_SUSP_SEL    = 6;
   localparam int          BIT_FLAG_CLR    = 5;
   localparam int          BIT_RST_WAKE    = 4;
   localparam int          WAKE_EN_W       = 4;
   localparam int          FLAG_W          = 5;
   // flash_timing_reg
   localparam int          BIT_BYPASS      = 6;
   // clock control
   localparam int          BIT_LP_OSC      = 0;
   localparam int          BIT_EXT_OSC     = 1;
   localparam int          BIT_WDT_EN      = 2;
   localparam int          BIT_MON_EN      = 3;
   localparam int          BIT_WDT_KICK    = 4;

   localparam logic [VEC_W-1:0] RESET_VECTOR = 16'h0000;
   localparam logic        LP_OSC_RST      = 1'h1;
   localparam logic        EXT_OSC_RST     = 1'h0;
   localparam logic        WDT_EN_RST      = 1'h1;
   localparam logic        MON_EN_RST      = 1'h1;

   localparam int          CLK_PERIOD_PS   = 8000;
   localparam int          MON_TIMEOUT_NS  = 100000;
   localparam int          MON_CYCLES_DEF  =
      (MON_TIMEOUT_NS * 1000) / CLK_PERIOD_PS;
   localparam int          WDT_CYCLES_DEF  = 65536;

   typedef enum logic [2:0] {
      PMC_NORMAL,
      PMC_IDLE,
      PMC_STOP,
      PMC_SUSPEND,
      PMC_SLEEP
   } pmc_mode_t;
endpackage

// ### src/pmc_timer_if.sv
// Purpose: control and expiry signals between controller and a timer
// Assumes: all signals on core_clk
// Notes:   expired is a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
interface pmc_timer_if;
   logic enable;
   logic run;
   logic kick;
   logic expired;
   modport ctrl  (output enable, output run, output kick, input expired);
   modport timer (input enable, input run, input kick, output expired);
endinterface
`default_nettype wire

// ### src/pmc_watchdog.sv
// Purpose: watchdog counter that can end idle with an internal reset
// Assumes: run is high whenever the core clock reaches peripherals
// Notes:   counts from zero again after each expiry
`timescale 1ns/1ps
`default_nettype none
module pmc_watchdog #(
   parameter int LIMIT = pmc_pkg::WDT_CYCLES_DEF
) (
   input  wire logic   core_clk,
   input  wire logic   reset,
   pmc_timer_if.timer  tmr
);
   import pmc_pkg::*;
   localparam int W = $clog2(LIMIT + 1);
   if (LIMIT < 2) $error("watchdog limit too small");

   typedef struct packed {
      logic [W-1:0] cnt;
      logic         expired;
   } pmc_wdt_state_t;

   pmc_wdt_state_t s, next_s;

   always_comb
   begin
      next_s = s;
      next_s.expired = 1'b0;
      if (!tmr.enable || tmr.kick)
         next_s.cnt = '0;
      else if (tmr.run)
      begin
         // keeps counting through idle
         if (s.cnt == W'(LIMIT - 1))
         begin
            next_s.cnt = '0;
            next_s.expired = 1'b1;
         end
         else
            next_s.cnt = s.cnt + W'(1);
      end
   end

   always_ff @(posedge core_clk or posedge reset)
      if (reset)
         s <= '0;
      else
         s <= next_s;

   assign tmr.expired = s.expired;
endmodule
`default_nettype wire

// ### src/pmc_clock_monitor.sv
// Purpose: lost clock monitor that raises an internal reset in stop
// Assumes: run is high while the core is stopped
// Notes:   timeout is a parameter so simulation can shorten it
`timescale 1ns/1ps
`default_nettype none
module pmc_clock_monitor #(
   parameter int LIMIT = pmc_pkg::MON_CYCLES_DEF
) (
   input  wire logic   core_clk,
   input  wire logic   reset,
   pmc_timer_if.timer  tmr
);
   import pmc_pkg::*;
   localparam int W = $clog2(LIMIT + 1);
   if (LIMIT < 2) $error("monitor timeout too small");

   typedef struct packed {
      logic [W-1:0] cnt;
      logic         expired;
   } pmc_mon_state_t;

   pmc_mon_state_t s, next_s;

   always_comb
   begin
      next_s = s;
      next_s.expired = 1'b0;
      if (!tmr.enable || !tmr.run || tmr.kick)
         next_s.cnt = '0;
      else if (s.cnt == W'(LIMIT - 1))
      begin
         // restart the count so expiry stays a single pulse
         next_s.cnt     = '0;
         next_s.expired = 1'b1;
      end
      else
         next_s.cnt = s.cnt + W'(1);
   end

   always_ff @(posedge core_clk or posedge reset)
      if (reset)
         s <= '0;
      else
         s <= next_s;

   assign tmr.expired = s.expired;
endmodule
`default_nettype wire

// ### src/pmc_power_mode_controller.sv
// Purpose: power mode selection and entry/exit sequencing for the core
// Assumes: instr_done pulses when the current instruction completes
// Notes:   all outputs are registered; read data valid one cycle later
`timescale 1ns/1ps
`default_nettype none
module pmc_power_mode_controller #(
   parameter int WDT_CYCLES = pmc_pkg::WDT_CYCLES_DEF,
   parameter int MON_CYCLES = pmc_pkg::MON_CYCLES_DEF
) (
   input  wire logic                       core_clk,
   input  wire logic                       reset,
   input  wire logic [pmc_pkg::ADDR_W-1:0] reg_addr,
   input  wire logic [pmc_pkg::DATA_W-1:0] reg_wdata,
   input  wire logic                       reg_wr,
   input  wire logic                       reg_rd,
   output var  logic [pmc_pkg::DATA_W-1:0] reg_rdata,
   input  wire logic                       instr_done,
   input  wire logic                       irq_pending,
   input  wire logic                       ext_rst_req,
   input  wire logic                       rst_pin_fall,
   input  wire logic                       rtc_osc_fail,
   input  wire logic                       rtc_alarm,
   input  wire logic                       port_match,
   input  wire logic                       cmp0_rise,
   input  wire logic                       two_cell_mode,
   output var  logic                       cpu_halt,
   output var  logic                       periph_clk_en,
   output var  logic                       prec_osc_en,
   output var  logic                       lp_osc_run,
   output var  logic                       ext_osc_run,
   output var  logic                       sysclk_gate,
   output var  logic                       supply_gate,
   output var  logic                       flash_bypass,
   output var  logic                       resume_irq,
   output var  logic                       resume_next,
   output var  logic                       restart_req,
   output var  logic [pmc_pkg::VEC_W-1:0]  restart_vec,
   output var  pmc_pkg::pmc_mode_t         mode
);
   import pmc_pkg::*;
   if (WDT_CYCLES < 2 || MON_CYCLES < 2) $error("timer counts too small");

   typedef struct packed {
      pmc_mode_t                mode;
      logic                     idle_sel;
      logic                     stop_sel;
      logic                     susp_sel;
      logic                     sleep_sel;
      logic [WAKE_EN_W-1:0]     wake_en;
      logic [FLAG_W-1:0]        wake_flag;
      logic                     bypass;
      logic                     lp_osc_en;
      logic                     ext_osc_en;
      logic                     wdt_en;
      logic                     mon_en;
      logic [DATA_W-1:0]        rdata;
      logic                     cpu_halt;
      logic                     periph_clk_en;
      logic                     prec_osc_en;
      logic                     lp_osc_run;
      logic                     ext_osc_run;
      logic                     sysclk_gate;
      logic                     supply_gate;
      logic                     resume_irq;
      logic                     resume_next;
      logic                     restart_req;
      logic [VEC_W-1:0]         restart_vec;
   } pmc_state_t;

   localparam pmc_state_t RESET_STATE = '{
      mode:          PMC_NORMAL,
      lp_osc_en:     LP_OSC_RST,
      ext_osc_en:    EXT_OSC_RST,
      wdt_en:        WDT_EN_RST,
      mon_en:        MON_EN_RST,
      periph_clk_en: 1'b1,
      prec_osc_en:   1'b1,
      lp_osc_run:    LP_OSC_RST,
      ext_osc_run:   EXT_OSC_RST,
      restart_vec:   RESET_VECTOR,
      default:       '0
   };

   pmc_state_t s, next_s;

   pmc_timer_if wdt_bus ();
   pmc_timer_if mon_bus ();

   logic                 any_rst;
   logic [FLAG_W-1:0]    wake_ev;
   logic [FLAG_W-1:0]    wake_mask;
   logic                 wr_ctrl;
   logic                 wr_cfg;
   logic                 wr_clk;

   assign any_rst   = ext_rst_req | wdt_bus.expired | mon_bus.expired;
   assign wake_ev   = {rst_pin_fall, rtc_osc_fail, rtc_alarm,
                       port_match, cmp0_rise};
   // reset pin wake is always armed
   assign wake_mask = {1'b1, s.wake_en};
   assign wr_ctrl   = reg_wr && reg_addr == OFS_POWER_CTRL;
   assign wr_cfg    = reg_wr && reg_addr == OFS_POWER_CFG;
   assign wr_clk    = reg_wr && reg_addr == OFS_CLK_CTRL;

   // watchdog runs whenever the peripheral clock does
   assign wdt_bus.enable = s.wdt_en;
   assign wdt_bus.run    = s.mode inside {PMC_NORMAL, PMC_IDLE};
   assign wdt_bus.kick   = wr_clk && reg_wdata[BIT_WDT_KICK];
   assign mon_bus.enable = s.mon_en;
   assign mon_bus.run    = s.mode == PMC_STOP;
   assign mon_bus.kick   = 1'b0;

   pmc_watchdog #(
      .LIMIT    (WDT_CYCLES)
   ) u_watchdog (
      .core_clk (core_clk),
      .reset    (reset),
      .tmr      (wdt_bus.timer)
   );

   pmc_clock_monitor #(
      .LIMIT    (MON_CYCLES)
   ) u_clock_monitor (
      .core_clk (core_clk),
      .reset    (reset),
      .tmr      (mon_bus.timer)
   );

   always_comb
   begin
      logic [FLAG_W-1:0] armed;
      armed = '0;
      next_s = s;
      next_s.rdata       = '0;
      next_s.resume_irq  = 1'b0;
      next_s.resume_next = 1'b0;
      next_s.restart_req = 1'b0;

      // flags always track events; a new event beats the clear
      if (wr_cfg && reg_wdata[BIT_FLAG_CLR])
         next_s.wake_flag = '0;
      next_s.wake_flag = next_s.wake_flag | wake_ev;

      armed = next_s.wake_flag & wake_mask;
      if (s.mode == PMC_SLEEP && !two_cell_mode)
         armed[0] = 1'b0;

      unique case (s.mode)
         PMC_NORMAL:
         begin
            if (instr_done)
            begin
               // suspend/sleep refused while an armed flag is still set
               if (s.sleep_sel && (s.wake_flag & wake_mask) == '0)
                  next_s.mode = PMC_SLEEP;
               else if (s.susp_sel && (s.wake_flag & wake_mask) == '0)
                  next_s.mode = PMC_SUSPEND;
               else if (s.stop_sel)
                  next_s.mode = PMC_STOP;
               else if (s.idle_sel)
                  next_s.mode = PMC_IDLE;
               next_s.susp_sel  = 1'b0;
               next_s.sleep_sel = 1'b0;
            end
         end
         PMC_IDLE:
         begin
            if (irq_pending)
            begin
               next_s.idle_sel   = 1'b0;
               next_s.mode       = PMC_NORMAL;
               // core vectors first, then returns past the idle write
               next_s.resume_irq = 1'b1;
            end
         end
         // stop leaves only through the reset path below
         PMC_STOP:
            next_s.mode = PMC_STOP;
         PMC_SUSPEND, PMC_SLEEP:
         begin
            if (armed != '0)
            begin
               next_s.mode        = PMC_NORMAL;
               next_s.resume_next = 1'b1;
            end
         end
      endcase

      // software writes land after the hardware clear
      if (wr_ctrl)
      begin
         next_s.idle_sel = reg_wdata[BIT_IDLE_SEL];
         next_s.stop_sel = reg_wdata[BIT_STOP_SEL];
      end
      if (wr_cfg)
      begin
         next_s.sleep_sel = reg_wdata[BIT_SLEEP_SEL];
         next_s.susp_sel  = reg_wdata[BIT_SUSP_SEL];
         next_s.wake_en   = reg_wdata[WAKE_EN_W-1:0];
      end
      if (reg_wr && reg_addr == OFS_FLASH_TIME)
         next_s.bypass = reg_wdata[BIT_BYPASS];
      if (wr_clk)
      begin
         next_s.lp_osc_en  = reg_wdata[BIT_LP_OSC];
         next_s.ext_osc_en = reg_wdata[BIT_EXT_OSC];
         next_s.wdt_en     = reg_wdata[BIT_WDT_EN];
         next_s.mon_en     = reg_wdata[BIT_MON_EN];
      end

      // internal or external reset: restart from the reset vector
      if (any_rst)
      begin
         next_s.mode        = PMC_NORMAL;
         next_s.idle_sel    = 1'b0;
         next_s.stop_sel    = 1'b0;
         next_s.susp_sel    = 1'b0;
         next_s.sleep_sel   = 1'b0;
         next_s.resume_irq  = 1'b0;
         next_s.resume_next = 1'b0;
         next_s.restart_req = 1'b1;
         next_s.restart_vec = RESET_VECTOR;
      end

      if (reg_rd)
      begin
         unique case (reg_addr)
            OFS_POWER_CTRL:
            begin
               next_s.rdata[BIT_IDLE_SEL] = s.idle_sel;
               next_s.rdata[BIT_STOP_SEL] = s.stop_sel;
            end
            OFS_POWER_CFG:
               next_s.rdata[FLAG_W-1:0] = s.wake_flag;
            OFS_FLASH_TIME:
               next_s.rdata[BIT_BYPASS] = s.bypass;
            OFS_CLK_CTRL:
            begin
               next_s.rdata[BIT_LP_OSC]  = s.lp_osc_en;
               next_s.rdata[BIT_EXT_OSC] = s.ext_osc_en;
               next_s.rdata[BIT_WDT_EN]  = s.wdt_en;
               next_s.rdata[BIT_MON_EN]  = s.mon_en;
            end
            OFS_STATUS:
               next_s.rdata[$bits(pmc_mode_t)-1:0] = s.mode;
            default:
               next_s.rdata = '0;
         endcase
      end

      // output decode from the mode being entered
      next_s.cpu_halt      = next_s.mode != PMC_NORMAL;
      next_s.periph_clk_en =
         next_s.mode inside {PMC_NORMAL, PMC_IDLE};
      next_s.prec_osc_en   =
         next_s.mode inside {PMC_NORMAL, PMC_IDLE};
      next_s.lp_osc_run    = next_s.lp_osc_en &&
         !(next_s.mode inside {PMC_SUSPEND, PMC_SLEEP});
      next_s.ext_osc_run   = next_s.ext_osc_en &&
         !(next_s.mode inside {PMC_SUSPEND, PMC_SLEEP});
      next_s.sysclk_gate   =
         next_s.mode inside {PMC_SUSPEND, PMC_SLEEP};
      next_s.supply_gate   = next_s.mode == PMC_SLEEP;
   end

   always_ff @(posedge core_clk or posedge reset)
      if (reset)
         s <= RESET_STATE;
      else
         s <= next_s;

   assign reg_rdata     = s.rdata;
   assign cpu_halt      = s.cpu_halt;
   assign periph_clk_en = s.periph_clk_en;
   assign prec_osc_en   = s.prec_osc_en;
   assign lp_osc_run    = s.lp_osc_run;
   assign ext_osc_run   = s.ext_osc_run;
   assign sysclk_gate   = s.sysclk_gate;
   assign supply_gate   = s.supply_gate;
   assign flash_bypass  = s.bypass;
   assign resume_irq    = s.resume_irq;
   assign resume_next   = s.resume_next;
   assign restart_req   = s.restart_req;
   assign restart_vec   = s.restart_vec;
   assign mode          = s.mode;

   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);

   chk_five_modes: assert property (
      s.mode inside {PMC_NORMAL, PMC_IDLE, PMC_STOP, PMC_SUSPEND, PMC_SLEEP})
      else $error("mode outside the five modes");
   chk_idle_entry: assert property (
      s.mode == PMC_NORMAL && s.idle_sel && !s.stop_sel && !s.susp_sel &&
      !s.sleep_sel && instr_done && !any_rst
      |=> s.mode == PMC_IDLE && cpu_halt)
      else $error("idle not entered after setting instruction");
   chk_idle_periph: assert property (
      s.mode == PMC_IDLE && $past(s.mode) == PMC_IDLE
      |-> cpu_halt && periph_clk_en && prec_osc_en)
      else $error("idle stopped more than the cpu");
   chk_idle_wake: assert property (
      s.mode == PMC_IDLE && irq_pending && !any_rst && !wr_ctrl
      |=> s.mode == PMC_NORMAL && !s.idle_sel && resume_irq
      ##1 !resume_irq)
      else $error("interrupt did not end idle");
   chk_reset_restart: assert property (
      any_rst |=> restart_req && restart_vec == RESET_VECTOR &&
      s.mode == PMC_NORMAL && !s.stop_sel)
      else $error("reset did not restart at the vector");
   chk_wdt_idle: assert property (
      s.mode == PMC_IDLE && wdt_bus.expired |=> restart_req && !cpu_halt)
      else $error("watchdog did not end idle");
   chk_stop_hold: assert property (
      s.mode == PMC_STOP && !any_rst |=> s.mode == PMC_STOP && !resume_irq)
      else $error("stop left without a reset");
   chk_stop_osc: assert property (
      s.mode == PMC_STOP |-> !prec_osc_en && cpu_halt &&
      lp_osc_run == s.lp_osc_en && ext_osc_run == s.ext_osc_en)
      else $error("stop oscillator state wrong");
   chk_susp_clock: assert property (
      s.mode == PMC_SUSPEND |-> sysclk_gate && !lp_osc_run && !prec_osc_en)
      else $error("suspend left a clock running");
   chk_sleep_cmp: assert property (
      s.mode == PMC_SLEEP && !two_cell_mode && (s.wake_flag & wake_mask) == '0
      && wake_ev == FLAG_W'(1) && !any_rst |=> s.mode == PMC_SLEEP)
      else $error("comparator woke sleep in one-cell mode");

   cov_idle_trip: cover property (
      s.mode == PMC_IDLE ##[1:50] resume_irq);
   cov_stop_restart: cover property (
      s.mode == PMC_STOP ##1 restart_req);
   cov_suspend_wake: cover property (
      s.mode == PMC_SUSPEND ##[1:50] resume_next);
   cov_sleep_wake: cover property (
      s.mode == PMC_SLEEP ##[1:50] resume_next);
endmodule
`default_nettype wire

// ### sim/pmc_testbench.sv
// Purpose: self-checking bench for the power mode controller
// Assumes: watchdog and monitor counts shortened for a quick run
// Notes:   inputs move by non-blocking assignment after rising edges,
//          outputs are sampled on the falling edge
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import pmc_pkg::*;
   localparam int WDT_N = 40;
   localparam int MON_N = 16;
   logic              core_clk;
   logic              reset;
   logic [ADDR_W-1:0] reg_addr;
   logic [DATA_W-1:0] reg_wdata;
   logic              reg_wr;
   logic              reg_rd;
   logic [DATA_W-1:0] reg_rdata;
   logic              instr_done;
   logic              irq_pending;
   logic              ext_rst_req;
   logic [4:0]        ev;
   logic              two_cell_mode;
   logic              cpu_halt;
   logic              periph_clk_en;
   logic              prec_osc_en;
   logic              lp_osc_run;
   logic              ext_osc_run;
   logic              sysclk_gate;
   logic              supply_gate;
   logic              flash_bypass;
   logic              resume_irq;
   logic              resume_next;
   logic              restart_req;
   logic [VEC_W-1:0]  restart_vec;
   pmc_mode_t         mode;
   logic [DATA_W-1:0] rd_val;
   int                fail_count;
   int                checks_done;
   int                cycles;
   // halt, periph, precision osc, lp osc, ext osc, clock gate, supply gate
   wire logic [6:0]   outs = {cpu_halt, periph_clk_en, prec_osc_en,
      lp_osc_run, ext_osc_run, sysclk_gate, supply_gate};

   pmc_power_mode_controller #(.WDT_CYCLES(WDT_N), .MON_CYCLES(MON_N))
   i_pmc_power_mode_controller (
      .core_clk(core_clk), .reset(reset), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .instr_done(instr_done),
      .irq_pending(irq_pending), .ext_rst_req(ext_rst_req),
      .rst_pin_fall(ev[4]), .rtc_osc_fail(ev[3]), .rtc_alarm(ev[2]),
      .port_match(ev[1]), .cmp0_rise(ev[0]),
      .two_cell_mode(two_cell_mode), .cpu_halt(cpu_halt),
      .periph_clk_en(periph_clk_en), .prec_osc_en(prec_osc_en),
      .lp_osc_run(lp_osc_run), .ext_osc_run(ext_osc_run),
      .sysclk_gate(sysclk_gate), .supply_gate(supply_gate),
      .flash_bypass(flash_bypass), .resume_irq(resume_irq),
      .resume_next(resume_next), .restart_req(restart_req),
      .restart_vec(restart_vec), .mode(mode));

   initial
   begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge core_clk);
      reg_wr    <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [2:0] a, input logic [7:0] exp);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge core_clk);
      reg_rd   <= 1'b0;
      @(negedge core_clk);
      rd_val = reg_rdata;
      chk(16'(rd_val), 16'(exp));
   endtask

   // select write, then the instruction that set it completes
   task automatic enter(input logic [2:0] a, input logic [7:0] d);
      wr(a, d);
      instr_done <= 1'b1;
      @(posedge core_clk);
      instr_done <= 1'b0;
      @(negedge core_clk);
   endtask

   // one-cycle pulse on {irq, ext reset, wake events}
   task automatic drive(input logic [6:0] v);
      @(posedge core_clk);
      {irq_pending, ext_rst_req, ev} <= v;
      @(posedge core_clk);
      {irq_pending, ext_rst_req, ev} <= 7'h00;
      @(negedge core_clk);
   endtask

   task automatic see(input pmc_mode_t m, input logic [6:0] o);
      chk(16'(mode), 16'(m));
      chk(16'(outs), 16'(o));
   endtask

   // bounded wait for a restart (sel 0) or resume (sel 1) pulse
   task automatic wait_out(input int sel, input int n);
      int  i;
      logic hit;
      hit = 1'b0;
      for (i = 0; i < n && hit !== 1'b1; i++)
      begin
         hit = (sel == 0) ? restart_req : resume_next;
         if (hit !== 1'b1)
            @(negedge core_clk);
      end
      chk(16'(hit), 16'h0001);
      chk(16'(mode), 16'(PMC_NORMAL));
   endtask

   always @(posedge core_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 3000)
      begin
         fail_count++;
         final_report();
      end
   end

   initial
   begin
      reset = 1'b1;
      {reg_addr, reg_wdata, reg_wr, reg_rd, instr_done} = '0;
      {irq_pending, ext_rst_req, ev, two_cell_mode} = '0;
      fail_count = 0;
      checks_done = 0;
      cycles = 0;
      repeat (12) @(posedge core_clk);
      reset <= 1'b0;
      @(negedge core_clk);
      see(PMC_NORMAL, 7'h38);
      chk(restart_vec, 16'h0000);
      rd(OFS_CLK_CTRL, 8'h0D);
      rd(3'h5, 8'h00);
      wr(OFS_CLK_CTRL, 8'h01);
      wr(OFS_FLASH_TIME, 8'h40);
      @(negedge core_clk);
      chk(16'(flash_bypass), 16'h0001);
      wr(OFS_FLASH_TIME, 8'h00);
      @(negedge core_clk);
      chk(16'(flash_bypass), 16'h0000);
      // idle: only the core halts, state held until the interrupt
      enter(OFS_POWER_CTRL, 8'h01);
      see(PMC_IDLE, 7'h78);
      rd(OFS_STATUS, 8'h01);
      rd(OFS_POWER_CTRL, 8'h01);
      drive(7'h40);
      see(PMC_NORMAL, 7'h38);
      chk(16'({resume_irq, restart_req}), 16'h0002);
      rd(OFS_POWER_CTRL, 8'h00);
      // reset out of idle
      enter(OFS_POWER_CTRL, 8'h01);
      drive(7'h20);
      chk(16'(restart_req), 16'h0001);
      see(PMC_NORMAL, 7'h38);
      // stop with both slow oscillators on and no monitor
      wr(OFS_CLK_CTRL, 8'h03);
      enter(OFS_POWER_CTRL, 8'h02);
      see(PMC_STOP, 7'h4C);
      drive(7'h40);
      drive(7'h1F);
      repeat (MON_N + 10) @(negedge core_clk);
      see(PMC_STOP, 7'h4C);
      chk(16'({resume_irq, resume_next}), 16'h0000);
      drive(7'h20);
      chk(16'(restart_req), 16'h0001);
      see(PMC_NORMAL, 7'h3C);
      rd(OFS_POWER_CTRL, 8'h00);
      // monitor enabled: internal reset ends stop
      wr(OFS_CLK_CTRL, 8'h09);
      enter(OFS_POWER_CTRL, 8'h02);
      see(PMC_STOP, 7'h48);
      wait_out(0, MON_N + 8);
      // watchdog enabled: internal reset ends idle
      wr(OFS_CLK_CTRL, 8'h05);
      enter(OFS_POWER_CTRL, 8'h01);
      // a kick late in the count must push the expiry out
      repeat (WDT_N - 10) @(negedge core_clk);
      wr(OFS_CLK_CTRL, 8'h15);
      repeat (20) @(negedge core_clk);
      see(PMC_IDLE, 7'h78);
      wait_out(0, WDT_N + 8);
      wr(OFS_CLK_CTRL, 8'h01);
      enter(OFS_POWER_CTRL, 8'h01);
      repeat (WDT_N + 10) @(negedge core_clk);
      see(PMC_IDLE, 7'h78);
      drive(7'h40);
      // suspend, port wake only; an unarmed alarm must not wake it
      wr(OFS_POWER_CFG, 8'h20);
      enter(OFS_POWER_CFG, 8'h42);
      see(PMC_SUSPEND, 7'h42);
      drive(7'h04);
      chk(16'(mode), 16'(PMC_SUSPEND));
      drive(7'h02);
      wait_out(1, 4);
      rd(OFS_POWER_CFG, 8'h06);
      // sleep in one-cell mode: comparator masked, pin edge wakes
      wr(OFS_POWER_CFG, 8'h20);
      enter(OFS_POWER_CFG, 8'h81);
      see(PMC_SLEEP, 7'h43);
      drive(7'h01);
      chk(16'(mode), 16'(PMC_SLEEP));
      drive(7'h10);
      wait_out(1, 4);
      @(posedge core_clk);
      two_cell_mode <= 1'b1;
      wr(OFS_POWER_CFG, 8'h20);
      enter(OFS_POWER_CFG, 8'h81);
      drive(7'h01);
      wait_out(1, 4);
      final_report();
   end
endmodule
`default_nettype wire
